// file: piu_pkg.sv
// Package with constants, types and helpers of the priority interrupt unit
// Summary of operation
// - Command A0H enables rotation when service ends
// - Command 20H clears highest in-service bit
// - Code 11100 clears named level, rotates priority
// - Code 01100 clears named in-service bit only
// - Code 11000 makes named level lowest priority
// - Command 0AH selects pending requests for reads
// - Command 0BH selects in-service bits for reads
// - Pending register mirrors active request inputs
// - In-service bits set on service, cleared by end
// - Read selection persists across command port reads
// - Mask port write stores mask, read returns it
// - 68H enters special mask mode, 48H leaves
// - Two acknowledges; identifier byte on the second
// - Master answers only for inputs without slave
// - Identifier joins vector base and input number
// - Master drives cascade code on first acknowledge, for slaved inputs only
// - Winning request raises the maskable request line
// - Slave keeps cascade identity for its answer
// - Slave answers second acknowledge on identity match
// - Identifier: base in upper five, level low three
// - Automatic ending clears in-service bit at acknowledge
// - Fixed nested priority holds after reset
package piu_pkg;

	localparam logic [15:0] CMD_PORT_OFS   = 16'h00C0;
	localparam logic [15:0] MASK_PORT_OFS  = 16'h00C2;
	localparam logic [7:0]  MASK_RESET     = 8'hFF;
	localparam logic [2:0]  LOWEST_RESET   = 3'h7;
	localparam logic [2:0]  SPURIOUS_LEVEL = 3'h7;

	// Command byte codes and field layout
	localparam logic [7:0] CMD_NS_END        = 8'h20;
	localparam logic [7:0] CMD_ROT_NS_END    = 8'hA0;
	localparam logic [7:0] CMD_READ_PENDING  = 8'h0A;
	localparam logic [7:0] CMD_READ_INSERV   = 8'h0B;
	localparam logic [7:0] CMD_SMM_ENTER     = 8'h68;
	localparam logic [7:0] CMD_SMM_LEAVE     = 8'h48;
	localparam logic [4:0] CMD_ROT_SPEC_END  = 5'h1C;
	localparam logic [4:0] CMD_SPEC_END      = 5'h0C;
	localparam logic [4:0] CMD_SET_PRIORITY  = 5'h18;
	localparam int         CMD_CODE_LSB      = 3;
	localparam int         VEC_BASE_LSB      = 3;

	typedef enum logic {ACK_IDLE, ACK_WAIT2} piu_ack_e;

	typedef struct packed {
		logic [7:0] pending;
		logic [7:0] inService;
		logic [7:0] maskBits;
		logic [2:0] lowest;
		logic       autoRotate;
		logic       specialMask;
		logic       readInService;
		piu_ack_e   ackState;
		logic [2:0] ackLevel;
		logic       ackValid;
		logic       intrLine;
		logic [2:0] cascCode;
		logic       cascOe;
		logic [7:0] vecData;
		logic       vecOe;
		logic [7:0] rdData;
	} piu_state_s;

	// Rank of a level, zero being the highest priority
	function automatic logic [2:0] piu_rank(input logic [2:0] lvl, input logic [2:0] low);
		piu_rank = lvl - low - 3'h1;
	endfunction : piu_rank

	function automatic logic [7:0] piu_onehot(input logic [2:0] lvl);
		piu_onehot = 8'h01 << lvl;
	endfunction : piu_onehot

endpackage : piu_pkg

// file: piu_resolver.sv
// Rotating priority resolver: highest-priority set bit
`timescale 1ns/100ps
module piu_resolver (
	// Candidate bits and bottom priority level
	input  wire logic [7:0] bits,
	input  wire logic [2:0] lowest,
	// Result
	output logic            found,
	output logic [2:0]      level
);

	logic [2:0] idx;

	always_comb begin
		found = 1'b0;
		level = 3'h0;
		idx   = 3'h0;
		// Walk from lowest to highest so the highest wins
		for (int i = 8; i >= 1; i--) begin
			idx = lowest + 3'(i);
			if (bits[idx]) begin
				found = 1'b1;
				level = idx;
			end
		end
	end

endmodule : piu_resolver

// file: piu_controller.sv
// Priority interrupt unit: command, mask, status and acknowledge logic
`timescale 1ns/100ps
module piu_controller (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Port bus
	input  wire logic        busSel,
	input  wire logic [15:0] busAddr,
	input  wire logic        busWr,
	input  wire logic        busRd,
	input  wire logic [7:0]  busWdata,
	output logic      [7:0]  busRdata,
	// Request inputs
	input  wire logic [7:0]  requestInputs,
	// Setup held from initialization
	input  wire logic [4:0]  cfgVectorBase,
	input  wire logic [7:0]  cfgSlaveMap,
	input  wire logic        cfgIsSlave,
	input  wire logic [2:0]  cfgCascadeId,
	input  wire logic        cfgAutoEnd,
	// Processor side
	input  wire logic        acknowledgeStrobe,
	output logic             maskableRequestLine,
	output logic      [7:0]  vecDataOut,
	output logic             vecDataOe,
	// Cascade lines
	input  wire logic [2:0]  cascIn,
	output logic      [2:0]  cascOut,
	output logic             cascOe
);

	piu_pkg::piu_state_s stReg;
	piu_pkg::piu_state_s stNext;

	logic       reqFound;
	logic [2:0] reqLevel;
	logic       isrFound;
	logic [2:0] isrLevel;
	logic [7:0] reqEligible;
	logic       pendingWin;
	logic       cmdWr;
	logic       maskWr;
	logic       cmdRd;
	logic       maskRd;
	logic [4:0] cmdCode;
	logic [2:0] cmdLevel;
	logic       answer2;

	assign cmdWr    = busSel && busWr && busAddr == piu_pkg::CMD_PORT_OFS;
	assign maskWr   = busSel && busWr && busAddr == piu_pkg::MASK_PORT_OFS;
	assign cmdRd    = busSel && busRd && busAddr == piu_pkg::CMD_PORT_OFS;
	assign maskRd   = busSel && busRd && busAddr == piu_pkg::MASK_PORT_OFS;
	assign cmdCode  = busWdata[7:piu_pkg::CMD_CODE_LSB];
	assign cmdLevel = busWdata[2:0];

	// Special mask mode lets lower levels in, but never one already in service
	assign reqEligible = stReg.pending & ~stReg.maskBits
		& (stReg.specialMask ? ~stReg.inService : 8'hFF);

	piu_resolver reqResolver (
		.bits   (reqEligible),
		.lowest (stReg.lowest),
		.found  (reqFound),
		.level  (reqLevel)
	);

	piu_resolver isrResolver (
		.bits   (stReg.inService),
		.lowest (stReg.lowest),
		.found  (isrFound),
		.level  (isrLevel)
	);

	// Outside special mask mode a request wins only above every level under service
	assign pendingWin = reqFound && (stReg.specialMask || !isrFound
		|| piu_pkg::piu_rank(reqLevel, stReg.lowest)
		< piu_pkg::piu_rank(isrLevel, stReg.lowest));

	// Second acknowledge answer: master for direct inputs, slave on match
	assign answer2 = cfgIsSlave ? (cascIn == cfgCascadeId)
		: !cfgSlaveMap[stReg.ackLevel];

	always_comb begin
		logic [7:0] clrBits;
		logic [7:0] setBits;
		clrBits = 8'h00;
		setBits = 8'h00;
		stNext  = stReg;

		stNext.pending = requestInputs;
		stNext.vecOe   = 1'b0;

		// Register writes
		if (maskWr) begin
			stNext.maskBits = busWdata;
		end
		if (cmdWr) begin
			if (busWdata == piu_pkg::CMD_NS_END) begin
				if (isrFound) begin
					clrBits = piu_pkg::piu_onehot(isrLevel);
					if (stReg.autoRotate) begin
						stNext.lowest = isrLevel;
					end
				end
			end else if (busWdata == piu_pkg::CMD_ROT_NS_END) begin
				stNext.autoRotate = 1'b1;
				if (isrFound) begin
					clrBits       = piu_pkg::piu_onehot(isrLevel);
					stNext.lowest = isrLevel;
				end
			end else if (cmdCode == piu_pkg::CMD_ROT_SPEC_END) begin
				clrBits       = piu_pkg::piu_onehot(cmdLevel);
				stNext.lowest = cmdLevel;
			end else if (cmdCode == piu_pkg::CMD_SPEC_END) begin
				clrBits = piu_pkg::piu_onehot(cmdLevel);
			end else if (cmdCode == piu_pkg::CMD_SET_PRIORITY) begin
				stNext.lowest = cmdLevel;
			end else if (busWdata == piu_pkg::CMD_READ_PENDING) begin
				stNext.readInService = 1'b0;
			end else if (busWdata == piu_pkg::CMD_READ_INSERV) begin
				stNext.readInService = 1'b1;
			end else if (busWdata == piu_pkg::CMD_SMM_ENTER) begin
				stNext.specialMask = 1'b1;
			end else if (busWdata == piu_pkg::CMD_SMM_LEAVE) begin
				stNext.specialMask = 1'b0;
			end
		end

		// Register reads; selection is kept between reads
		if (cmdRd) begin
			stNext.rdData = stReg.readInService ? stReg.inService
				: stReg.pending;
		end else if (maskRd) begin
			stNext.rdData = stReg.maskBits;
		end else if (busSel && busRd) begin
			stNext.rdData = 8'h00;
		end

		// Acknowledge sequence
		case (stReg.ackState)
			piu_pkg::ACK_IDLE: begin
				if (acknowledgeStrobe) begin
					stNext.ackState = piu_pkg::ACK_WAIT2;
					stNext.ackValid = pendingWin;
					stNext.ackLevel = pendingWin ? reqLevel : piu_pkg::SPURIOUS_LEVEL;
					if (pendingWin && !cfgIsSlave) begin
						setBits = piu_pkg::piu_onehot(reqLevel);
						if (cfgSlaveMap[reqLevel]) begin
							stNext.cascCode = reqLevel;
							stNext.cascOe   = 1'b1;
						end
					end
				end
			end
			piu_pkg::ACK_WAIT2: begin
				if (acknowledgeStrobe) begin
					stNext.ackState = piu_pkg::ACK_IDLE;
					stNext.cascOe   = 1'b0;
					stNext.vecOe    = answer2;
					stNext.vecData  = {cfgVectorBase, stReg.ackLevel};
					if (cfgIsSlave && answer2 && stReg.ackValid) begin
						setBits = piu_pkg::piu_onehot(stReg.ackLevel);
					end
					if (cfgAutoEnd && stReg.ackValid) begin
						// Auto end cancels this cycle's set of the same level
						clrBits = clrBits | piu_pkg::piu_onehot(stReg.ackLevel);
						setBits = 8'h00;
						if (stReg.autoRotate) begin
							stNext.lowest = stReg.ackLevel;
						end
					end
				end
			end
			default: begin
				stNext.ackState = piu_pkg::ACK_IDLE;
			end
		endcase

		// Set wins over clear
		stNext.inService = (stReg.inService & ~clrBits) | setBits;
		stNext.intrLine  = pendingWin && stReg.ackState == piu_pkg::ACK_IDLE
			&& !acknowledgeStrobe;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stReg               <= '0;
			stReg.maskBits      <= piu_pkg::MASK_RESET;
			stReg.lowest        <= piu_pkg::LOWEST_RESET;
			stReg.ackState      <= piu_pkg::ACK_IDLE;
		end else begin
			stReg <= stNext;
		end
	end

	assign busRdata            = stReg.rdData;
	assign maskableRequestLine = stReg.intrLine;
	assign vecDataOut          = stReg.vecData;
	assign vecDataOe           = stReg.vecOe;
	assign cascOut             = stReg.cascCode;
	assign cascOe              = stReg.cascOe;

	// Checks
	irr_track_a: assert property (@(posedge clk) disable iff (!nrst)
		##1 stReg.pending == $past(requestInputs))
		else $error("pending register does not follow inputs");

	mask_write_a: assert property (@(posedge clk) disable iff (!nrst)
		maskWr |=> stReg.maskBits == $past(busWdata))
		else $error("mask write not stored");

	ns_end_a: assert property (@(posedge clk) disable iff (!nrst)
		cmdWr && busWdata == 8'h20 && isrFound && !acknowledgeStrobe
		|=> !stReg.inService[$past(isrLevel)])
		else $error("nonspecific end left bit set");

	read_select_a: assert property (@(posedge clk) disable iff (!nrst)
		cmdWr && busWdata == 8'h0A |=> !stReg.readInService)
		else $error("request register not selected");

	read_irr_a: assert property (@(posedge clk) disable iff (!nrst)
		cmdRd && !stReg.readInService |=> stReg.rdData == $past(stReg.pending))
		else $error("request register not returned");

	read_isr_a: assert property (@(posedge clk) disable iff (!nrst)
		cmdRd && stReg.readInService |=> stReg.rdData == $past(stReg.inService))
		else $error("in-service register not returned");

	rot_spec_a: assert property (@(posedge clk) disable iff (!nrst)
		cmdWr && busWdata[7:3] == 5'h1C && !acknowledgeStrobe
		|=> stReg.lowest == $past(busWdata[2:0])
		&& !stReg.inService[$past(busWdata[2:0])])
		else $error("rotate specific end failed");

	set_priority_a: assert property (@(posedge clk) disable iff (!nrst)
		cmdWr && busWdata[7:3] == 5'h18 && !acknowledgeStrobe
		|=> stReg.lowest == $past(busWdata[2:0]) && $stable(stReg.inService))
		else $error("set priority altered service bits");

	spec_end_a: assert property (@(posedge clk) disable iff (!nrst)
		cmdWr && busWdata[7:3] == 5'h0C && !acknowledgeStrobe
		|=> !stReg.inService[$past(busWdata[2:0])] && $stable(stReg.lowest))
		else $error("specific end failed or moved priority");

	smm_enter_a: assert property (@(posedge clk) disable iff (!nrst)
		cmdWr && busWdata == 8'h68 |=> stReg.specialMask ##0
		(!(cmdWr && busWdata == 8'h48)) [*1] |=> stReg.specialMask)
		else $error("special mask mode not held");

	smm_leave_a: assert property (@(posedge clk) disable iff (!nrst)
		cmdWr && busWdata == 8'h48 |=> !stReg.specialMask)
		else $error("special mask mode not left");

	vector_a: assert property (@(posedge clk) disable iff (!nrst)
		vecDataOe |-> vecDataOut == {cfgVectorBase, stReg.ackLevel}
		&& $past(stReg.ackState) == piu_pkg::ACK_WAIT2)
		else $error("identifier byte malformed");

	cascade_a: assert property (@(posedge clk) disable iff (!nrst)
		cascOe |-> !cfgIsSlave && cfgSlaveMap[cascOut]
		&& stReg.ackState == piu_pkg::ACK_WAIT2)
		else $error("cascade code driven wrongly");

	master_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		stReg.ackState == piu_pkg::ACK_WAIT2 && acknowledgeStrobe && !cfgIsSlave
		&& cfgSlaveMap[stReg.ackLevel] |=> !vecDataOe)
		else $error("master answered for a slaved input");

	slave_match_a: assert property (@(posedge clk) disable iff (!nrst)
		stReg.ackState == piu_pkg::ACK_WAIT2 && acknowledgeStrobe && cfgIsSlave
		&& cascIn != cfgCascadeId |=> !vecDataOe)
		else $error("slave answered without identity match");

	maskable_request_line_a: assert property (@(posedge clk) disable iff (!nrst)
		pendingWin && stReg.ackState == piu_pkg::ACK_IDLE && !acknowledgeStrobe
		|=> maskableRequestLine)
		else $error("request line not raised");

	ack_drop_a: assert property (@(posedge clk) disable iff (!nrst)
		acknowledgeStrobe && stReg.ackState == piu_pkg::ACK_IDLE
		|=> !maskableRequestLine)
		else $error("request line held through acknowledge");

	isr_set_a: assert property (@(posedge clk) disable iff (!nrst)
		acknowledgeStrobe && stReg.ackState == piu_pkg::ACK_IDLE && pendingWin
		&& !cfgIsSlave |=> stReg.inService[$past(reqLevel)])
		else $error("in-service bit not set at acknowledge");

	rotate_mode_a: assert property (@(posedge clk) disable iff (!nrst)
		cmdWr && busWdata == 8'hA0 |=> stReg.autoRotate)
		else $error("automatic rotation not entered");

	auto_end_a: assert property (@(posedge clk) disable iff (!nrst)
		stReg.ackState == piu_pkg::ACK_WAIT2 && acknowledgeStrobe && cfgAutoEnd
		&& stReg.ackValid |=> !stReg.inService[$past(stReg.ackLevel)])
		else $error("automatic ending left bit set");

	ack_pair_c: cover property (@(posedge clk) disable iff (!nrst)
		maskableRequestLine ##1 acknowledgeStrobe ##[1:8] vecDataOe);

	cascade_c: cover property (@(posedge clk) disable iff (!nrst)
		cascOe ##[1:8] !cascOe);

	rotate_c: cover property (@(posedge clk) disable iff (!nrst)
		stReg.autoRotate && cmdWr && busWdata == 8'h20 && isrFound);

	slave_c: cover property (@(posedge clk) disable iff (!nrst)
		cfgIsSlave && vecDataOe);

endmodule : piu_controller

// file: piu_cpu_model.sv
// Processor model: answers the unit's request line with two acknowledge pulses
`timescale 1ns/100ps
module piu_cpu_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Unit side
	input  wire logic       intrLine,
	input  wire logic [7:0] vecData,
	input  wire logic       vecOe,
	input  wire logic [2:0] cascCode,
	input  wire logic       cascOn,
	// Cycles waited before the first acknowledge
	input  wire logic [3:0] lag,
	// Acknowledge and what came back
	output logic            ack,
	output logic [7:0]      lastVec,
	output logic            lastOe,
	output logic [3:0]      lastCasc,
	output int              seqCnt
);
	initial begin
		ack = 1'b0;
		lastVec = 8'h00;
		lastOe = 1'b0;
		lastCasc = 4'h0;
		seqCnt = 0;
		forever begin
			@(negedge clk);
			if (nrst && intrLine) begin
				repeat (lag) @(negedge clk);
				ack = 1'b1;
				@(negedge clk);
				ack = 1'b0;
				@(negedge clk);
				lastCasc = {cascOn, cascCode};
				ack = 1'b1;
				@(negedge clk);
				ack = 1'b0;
				lastOe = vecOe;
				lastVec = vecData;
				seqCnt++;
			end
		end
	end
endmodule : piu_cpu_model

// file: tb.sv
// Self-checking testbench of the priority interrupt unit
`timescale 1ns/100ps
module tb;
	localparam logic [15:0] CMD  = piu_pkg::CMD_PORT_OFS;
	localparam logic [15:0] MSK  = piu_pkg::MASK_PORT_OFS;
	localparam logic [4:0]  BASE = 5'h15;
	localparam logic [2:0]  SID  = 3'h5;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        busSel = 1'b0;
	logic [15:0] busAddr = 16'h0000;
	logic        busWr = 1'b0;
	logic        busRd = 1'b0;
	logic [7:0]  busWdata = 8'h00;
	logic [7:0]  busRdata;
	logic [7:0]  requestInputs = 8'h00;
	logic        cfgAutoEnd = 1'b0;
	logic        cfgIsSlave = 1'b0;
	logic [2:0]  cascIn = 3'h0;
	logic        ack;
	logic        maskable_request_line;
	logic [7:0]  vecData;
	logic        vecOe;
	logic [2:0]  cascOut;
	logic        cascOe;
	logic [3:0]  lag = 4'h0;
	logic [7:0]  lastVec;
	logic        lastOe;
	logic [3:0]  lastCasc;
	int          seqCnt;
	int          failures = 0;
	int          checked = 0;
	always #2.5 clk = ~clk;
	piu_controller dut_u (.clk(clk), .nrst(nrst), .busSel(busSel), .busAddr(busAddr),
		.busWr(busWr), .busRd(busRd), .busWdata(busWdata), .busRdata(busRdata),
		.requestInputs(requestInputs), .cfgVectorBase(BASE), .cfgSlaveMap(8'h40),
		.cfgIsSlave(cfgIsSlave), .cfgCascadeId(SID), .cfgAutoEnd(cfgAutoEnd),
		.acknowledgeStrobe(ack), .maskableRequestLine(maskable_request_line), .vecDataOut(vecData),
		.vecDataOe(vecOe), .cascIn(cascIn), .cascOut(cascOut), .cascOe(cascOe));
	piu_cpu_model cpu_u (.clk(clk), .nrst(nrst), .intrLine(maskable_request_line), .vecData(vecData),
		.vecOe(vecOe), .cascCode(cascOut), .cascOn(cascOe), .lag(lag), .ack(ack),
		.lastVec(lastVec), .lastOe(lastOe), .lastCasc(lastCasc), .seqCnt(seqCnt));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		{busSel, busWr, busAddr, busWdata} = {2'b11, a, d};
		@(negedge clk);
		{busSel, busWr} = 2'b00;
	endtask : wr
	task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
		@(negedge clk);
		{busSel, busRd, busAddr} = {2'b11, a};
		@(negedge clk);
		{busSel, busRd} = 2'b00;
		chk(busRdata, exp);
	endtask : rdc
	// Raise requests, drop to rest once acknowledged, wait for the full pair
	task automatic serve(input logic [7:0] req, input logic [7:0] rest);
		int n;
		n = seqCnt;
		@(negedge clk);
		requestInputs = req;
		for (int i = 0; i < 40 && !ack; i++) @(negedge clk);
		requestInputs = rest;
		for (int i = 0; i < 40 && seqCnt == n; i++) @(negedge clk);
	endtask : serve
	task automatic serve_chk(input logic [7:0] req, input logic [7:0] rest, input logic [2:0] lvl);
		serve(req, rest);
		chk(lastVec, {BASE, lvl});
		chk({7'h00, lastOe}, 8'h01);
	endtask : serve_chk
	task automatic t_regs;
		rdc(MSK, 8'hFF);
		rdc(CMD, 8'h00);
		wr(MSK, 8'h5A);
		wr(16'h0010, 8'h00);
		rdc(MSK, 8'h5A);
		rdc(16'h0010, 8'h00);
		wr(MSK, 8'hFF);
		$display("done regs");
	endtask : t_regs
	task automatic t_status;
		requestInputs = 8'h81;
		wr(CMD, 8'h0A);
		rdc(CMD, 8'h81);
		rdc(CMD, 8'h81);
		wr(CMD, 8'h0B);
		rdc(CMD, 8'h00);
		rdc(CMD, 8'h00);
		chk(8'(seqCnt), 8'h00);
		requestInputs = 8'h00;
		$display("done status");
	endtask : t_status
	task automatic t_nested;
		int n;
		wr(MSK, 8'h00);
		serve_chk(8'h24, 8'h20, 3'h2);
		n = seqCnt;
		repeat (12) @(negedge clk);
		chk(8'(seqCnt), 8'(n));
		rdc(CMD, 8'h04);
		wr(CMD, 8'h62);
		serve_chk(8'h20, 8'h00, 3'h5);
		rdc(CMD, 8'h20);
		wr(CMD, 8'h20);
		rdc(CMD, 8'h00);
		$display("done nested");
	endtask : t_nested
	task automatic t_rotate;
		wr(CMD, 8'hC3);
		serve_chk(8'h24, 8'h00, 3'h5);
		wr(CMD, 8'hE5);
		rdc(CMD, 8'h00);
		serve_chk(8'h24, 8'h00, 3'h2);
		wr(CMD, 8'h20);
		wr(CMD, 8'hC7);
		serve_chk(8'h08, 8'h00, 3'h3);
		wr(CMD, 8'hA0);
		rdc(CMD, 8'h00);
		serve_chk(8'h14, 8'h00, 3'h4);
		wr(CMD, 8'h20);
		serve_chk(8'h24, 8'h00, 3'h5);
		wr(CMD, 8'h20);
		rdc(CMD, 8'h00);
		$display("done rotate");
	endtask : t_rotate
	task automatic t_special;
		serve_chk(8'h02, 8'h00, 3'h1);
		wr(CMD, 8'h68);
		serve_chk(8'h08, 8'h00, 3'h3);
		wr(CMD, 8'h48);
		rdc(CMD, 8'h0A);
		wr(CMD, 8'h61);
		wr(CMD, 8'h63);
		rdc(CMD, 8'h00);
		$display("done special");
	endtask : t_special
	task automatic t_cascade;
		lag = 4'h3;
		serve(8'h40, 8'h00);
		chk({4'h0, lastCasc}, 8'h0E);
		chk({7'h00, lastOe}, 8'h00);
		rdc(CMD, 8'h40);
		wr(CMD, 8'h66);
		lag = 4'h0;
		cfgAutoEnd = 1'b1;
		serve_chk(8'h08, 8'h00, 3'h3);
		rdc(CMD, 8'h00);
		cfgAutoEnd = 1'b0;
		$display("done cascade");
	endtask : t_cascade
	task automatic t_slave;
		cfgIsSlave = 1'b1;
		cascIn = SID;
		serve_chk(8'h10, 8'h00, 3'h4);
		rdc(CMD, 8'h10);
		wr(CMD, 8'h20);
		cascIn = 3'h2;
		serve(8'h10, 8'h00);
		chk({7'h00, lastOe}, 8'h00);
		rdc(CMD, 8'h00);
		cfgIsSlave = 1'b0;
		cascIn = 3'h0;
		$display("done slave");
	endtask : t_slave
	task automatic close_out;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	initial begin
		#20000;
		failures++;
		$display("BAD t=%0t watchdog expired", $time);
		close_out();
	end
	initial begin
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		t_regs();
		t_status();
		t_nested();
		t_rotate();
		t_special();
		t_cascade();
		t_slave();
		close_out();
	end
endmodule : tb
